// ### core/pcs_link_pkg.sv
package pcs_link_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ        = 20;
  localparam int LINK_TIMER_NS  = 1600000;
  localparam int LINK_TIMER_CYC = LINK_TIMER_NS * CLK_MHZ / 1000;
  localparam int TIMER_W        = 16;
  localparam int MDC_MAX_KHZ    = 2500;
  localparam int SYNC_GOOD      = 4;
  // ==========================================================
  // apb register map
  localparam logic [11:0] CTRL_OFF     = 12'h000;
  localparam logic [11:0] STAT_OFF     = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h00C;
  localparam int CTRL_AN_EN   = 0;
  localparam int CTRL_ISOLATE = 1;
  localparam int CTRL_UNIDIR  = 2;
  localparam int CTRL_RESTART = 3;
  localparam int STAT_SV_LSB  = 16;
  localparam int IRQ_AN_DONE  = 0;
  localparam int IRQ_LINK_UP  = 1;
  localparam int IRQ_LINK_DN  = 2;
  localparam int IRQ_W        = 3;
  // ==========================================================
  // management frame
  localparam logic [4:0] MREG_CTRL = 5'h00;
  localparam logic [4:0] MREG_STAT = 5'h01;
  localparam int MC_AN_EN   = 12;
  localparam int MC_ISOLATE = 10;
  localparam int MC_RESTART = 9;
  localparam int MC_UNIDIR  = 5;
  localparam int MS_LINK    = 2;
  localparam int MS_AN_ABLE = 3;
  localparam int MS_AN_DONE = 5;
  localparam logic [5:0] MDIO_PRE_LEN  = 6'h20;
  localparam logic [5:0] MDIO_HDR_LAST = 6'h0C;
  localparam logic [5:0] MDIO_DAT_LAST = 6'h0F;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // ==========================================================
  // state encodings
  typedef enum logic {SYNC_LOSS, SYNC_OK} sync_e;
  typedef enum logic [1:0] {AN_OFF, AN_ABILITY, AN_ACK, AN_DONE} an_e;
  typedef enum logic [2:0] {M_PRE, M_HDR, M_TA, M_RD, M_WR} mdio_e;
endpackage

// ### core/pcs_link_status.sv
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
// Functional notes
// R01: management clock must not exceed 2.5 MHz
// R02: answer management frames only at own address
// R03: vector bit0 sync, bit1 valid link
// R04: block transmit until link, unidirectional overrides
// R05: isolate after reset; no GMII transfer
// R06: status register bit 5 shows negotiation done
// R07: status register bit 2 equals vector bit1
// R08: interrupt output signals negotiation completion
// R09: bit error during handshake restarts negotiation
// R10: negotiation completes only if both enabled
// R11: medium absent holds receiver in loss-of-sync
// R12: medium input tied high without optical module
// R13: receive bit errors reach MAC as errors
// R14: transceiver resets held until PLL locks
module pcs_link_status #(
  parameter int LINK_TIMER_CYC = pcs_link_pkg::LINK_TIMER_CYC
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [4:0]  phy_addr,
  // medium and transceiver
  input  wire logic        signal_detect,
  input  wire logic        pll_locked,
  output logic             gt_tx_reset,
  output logic             gt_rx_reset,
  // code group decoder
  input  wire logic        code_valid,
  input  wire logic        code_error,
  input  wire logic        partner_ability,
  input  wire logic        partner_ack,
  // client transmit
  input  wire logic [7:0]  gmii_txd,
  input  wire logic        gmii_tx_en,
  input  wire logic        gmii_tx_er,
  output logic      [7:0]  pcs_txd,
  output logic             pcs_tx_en,
  output logic             pcs_tx_er,
  // client receive
  input  wire logic [7:0]  pcs_rxd,
  input  wire logic        pcs_rx_dv,
  input  wire logic        pcs_rx_er,
  output logic      [7:0]  gmii_rxd,
  output logic             gmii_rx_dv,
  output logic             gmii_rx_er,
  // status
  output logic      [1:0]  status_vector
);

  localparam logic [pcs_link_pkg::TIMER_W-1:0] TIMER_MAX =
    pcs_link_pkg::TIMER_W'(LINK_TIMER_CYC - 1);
  localparam logic [2:0] SYNC_LAST = 3'(pcs_link_pkg::SYNC_GOOD - 1);

  typedef struct packed {
    logic                             sd1, sd2, pl1, pl2;
    logic                             mdc1, mdc2, mdc3, mdi1, mdi2;
    logic [4:0]                       pa1, pa2;
    pcs_link_pkg::sync_e              sync_st;
    logic [2:0]                       good_cnt;
    pcs_link_pkg::an_e                an_st;
    logic [pcs_link_pkg::TIMER_W-1:0] timer;
    logic                             an_en, isolate, unidir, restart;
    logic                             link_prev;
    logic [pcs_link_pkg::IRQ_W-1:0]   irq_stat, irq_mask;
    logic                             irq;
    logic                             pready, pslverr;
    logic [31:0]                      prdata;
    pcs_link_pkg::mdio_e              m_st;
    logic [5:0]                       m_cnt;
    logic [12:0]                      m_hdr;
    logic [15:0]                      m_sh;
    logic                             m_out, m_oe;
    logic [7:0]                       txd, rxd;
    logic                             tx_en, tx_er, rx_dv, rx_er;
    logic [1:0]                       sv;
    logic                             gt_rst;
  } state_s;

  state_s r;
  state_s n;

  // ==========================================================
  // helpers
  function automatic logic link_of(input pcs_link_pkg::sync_e s, input pcs_link_pkg::an_e a,
                                   input logic an_en);
    link_of = (s == pcs_link_pkg::SYNC_OK) && (!an_en || a == pcs_link_pkg::AN_DONE);
  endfunction

  function automatic logic [15:0] mgmt_stat(input logic link, input logic an_done);
    mgmt_stat = '0;
    mgmt_stat[pcs_link_pkg::MS_LINK]    = link; // R07
    mgmt_stat[pcs_link_pkg::MS_AN_ABLE] = 1'b1;
    mgmt_stat[pcs_link_pkg::MS_AN_DONE] = an_done; // R06
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // next state
  logic                           link_now, link_new, an_done, rise, wr_fire, rd_op;
  logic [12:0]                    hdr;
  logic [pcs_link_pkg::IRQ_W-1:0] ev, w1c;

  always_comb begin
    n        = r;
    w1c      = '0;
    ev       = '0;
    hdr      = r.m_hdr;
    link_now = link_of(r.sync_st, r.an_st, r.an_en);
    an_done  = (r.an_st == pcs_link_pkg::AN_DONE);
    rise     = r.mdc2 && !r.mdc3;
    rd_op    = (r.m_hdr[11:10] == pcs_link_pkg::OP_READ);
    wr_fire  = psel && penable && r.pready && pwrite;

    // pin synchronisers; the first stage feeds only the second
    n.sd1  = signal_detect;
    n.sd2  = r.sd1;
    n.pl1  = pll_locked;
    n.pl2  = r.pl1;
    n.mdc1 = mdc;
    n.mdc2 = r.mdc1;
    n.mdc3 = r.mdc2;
    n.mdi1 = mdio_in;
    n.mdi2 = r.mdi1;
    n.pa1  = phy_addr;
    n.pa2  = r.pa1;
    n.restart = 1'b0;
    n.gt_rst  = !r.pl2; // R14

    // apb: one wait state, answer registered
    n.pready  = psel && penable && !r.pready;
    n.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      n.prdata  = '0;
      n.pslverr = 1'b1;
      if (hit(paddr, pcs_link_pkg::CTRL_OFF)) begin
        n.pslverr = 1'b0;
        n.prdata[pcs_link_pkg::CTRL_AN_EN]   = r.an_en;
        n.prdata[pcs_link_pkg::CTRL_ISOLATE] = r.isolate;
        n.prdata[pcs_link_pkg::CTRL_UNIDIR]  = r.unidir;
      end
      if (hit(paddr, pcs_link_pkg::STAT_OFF)) begin
        n.pslverr = 1'b0;
        n.prdata  = {14'h0000, r.sv, mgmt_stat(link_now, an_done)};
      end
      if (hit(paddr, pcs_link_pkg::IRQ_STAT_OFF)) begin
        n.pslverr = 1'b0;
        n.prdata[pcs_link_pkg::IRQ_W-1:0] = r.irq_stat;
      end
      if (hit(paddr, pcs_link_pkg::IRQ_MASK_OFF)) begin
        n.pslverr = 1'b0;
        n.prdata[pcs_link_pkg::IRQ_W-1:0] = r.irq_mask;
      end
    end
    if (wr_fire && hit(paddr, pcs_link_pkg::CTRL_OFF)) begin
      n.an_en   = pwdata[pcs_link_pkg::CTRL_AN_EN];
      n.isolate = pwdata[pcs_link_pkg::CTRL_ISOLATE];
      n.unidir  = pwdata[pcs_link_pkg::CTRL_UNIDIR];
      n.restart = pwdata[pcs_link_pkg::CTRL_RESTART];
    end
    if (wr_fire && hit(paddr, pcs_link_pkg::IRQ_STAT_OFF)) begin
      w1c = pwdata[pcs_link_pkg::IRQ_W-1:0];
    end
    if (wr_fire && hit(paddr, pcs_link_pkg::IRQ_MASK_OFF)) begin
      n.irq_mask = pwdata[pcs_link_pkg::IRQ_W-1:0];
    end

    // management frames, sampled on the synchronised clock edge;
    // the slow clock leaves eight system cycles per bit
    if (rise) begin // R01
      case (r.m_st)
        pcs_link_pkg::M_PRE: begin
          if (r.mdi2) begin
            if (r.m_cnt != pcs_link_pkg::MDIO_PRE_LEN) begin
              n.m_cnt = r.m_cnt + 6'h01;
            end
          end else begin
            n.m_cnt = '0;
            if (r.m_cnt == pcs_link_pkg::MDIO_PRE_LEN) begin
              n.m_st = pcs_link_pkg::M_HDR;
            end
          end
        end
        pcs_link_pkg::M_HDR: begin
          hdr     = {r.m_hdr[11:0], r.mdi2};
          n.m_hdr = hdr;
          n.m_cnt = r.m_cnt + 6'h01;
          if (r.m_cnt == pcs_link_pkg::MDIO_HDR_LAST) begin
            n.m_cnt = '0;
            n.m_st  = pcs_link_pkg::M_PRE;
            // other addresses: stay silent for the whole frame
            if (hdr[12] && hdr[9:5] == r.pa2 && (hdr[11:10] == pcs_link_pkg::OP_READ ||
                hdr[11:10] == pcs_link_pkg::OP_WRITE)) begin // R02
              n.m_st = pcs_link_pkg::M_TA;
              n.m_sh = '0;
              if (hdr[4:0] == pcs_link_pkg::MREG_STAT) begin
                n.m_sh = mgmt_stat(link_now, an_done);
              end
              if (hdr[4:0] == pcs_link_pkg::MREG_CTRL) begin
                n.m_sh[pcs_link_pkg::MC_AN_EN]   = r.an_en;
                n.m_sh[pcs_link_pkg::MC_ISOLATE] = r.isolate;
                n.m_sh[pcs_link_pkg::MC_UNIDIR]  = r.unidir;
              end
            end
          end
        end
        pcs_link_pkg::M_TA: begin
          n.m_cnt = r.m_cnt + 6'h01;
          if (rd_op) begin
            n.m_oe  = 1'b1;
            n.m_out = 1'b0;
          end
          if (r.m_cnt != 6'h00) begin
            n.m_cnt = '0;
            n.m_st  = rd_op ? pcs_link_pkg::M_RD : pcs_link_pkg::M_WR;
            if (rd_op) begin
              n.m_out = r.m_sh[15];
              n.m_sh  = {r.m_sh[14:0], 1'b0};
            end
          end
        end
        pcs_link_pkg::M_RD: begin
          n.m_cnt = r.m_cnt + 6'h01;
          n.m_out = r.m_sh[15];
          n.m_sh  = {r.m_sh[14:0], 1'b0};
          if (r.m_cnt == pcs_link_pkg::MDIO_DAT_LAST) begin
            n.m_oe  = 1'b0;
            n.m_out = 1'b0;
            n.m_cnt = '0;
            n.m_st  = pcs_link_pkg::M_PRE;
          end
        end
        pcs_link_pkg::M_WR: begin
          n.m_sh  = {r.m_sh[14:0], r.mdi2};
          n.m_cnt = r.m_cnt + 6'h01;
          if (r.m_cnt == pcs_link_pkg::MDIO_DAT_LAST) begin
            n.m_cnt = '0;
            n.m_st  = pcs_link_pkg::M_PRE;
            if (r.m_hdr[4:0] == pcs_link_pkg::MREG_CTRL) begin
              n.an_en   = n.m_sh[pcs_link_pkg::MC_AN_EN];
              n.isolate = n.m_sh[pcs_link_pkg::MC_ISOLATE];
              n.unidir  = n.m_sh[pcs_link_pkg::MC_UNIDIR];
              n.restart = n.m_sh[pcs_link_pkg::MC_RESTART];
            end
          end
        end
        default: begin
          n.m_st = pcs_link_pkg::M_PRE;
          n.m_oe = 1'b0;
        end
      endcase
    end

    // receiver synchronisation
    case (r.sync_st)
      pcs_link_pkg::SYNC_LOSS: begin
        if (code_error) begin
          n.good_cnt = '0;
        end else if (code_valid) begin
          n.good_cnt = r.good_cnt + 3'h1;
          if (r.good_cnt == SYNC_LAST) begin
            n.sync_st = pcs_link_pkg::SYNC_OK;
          end
        end
      end
      pcs_link_pkg::SYNC_OK: begin
        if (code_error) begin
          n.sync_st  = pcs_link_pkg::SYNC_LOSS;
          n.good_cnt = '0;
        end
      end
      default: n.sync_st = pcs_link_pkg::SYNC_LOSS;
    endcase
    if (!r.sd2) begin // R11
      n.sync_st  = pcs_link_pkg::SYNC_LOSS;
      n.good_cnt = '0;
    end

    // auto-negotiation; each handshake step lasts a full link timer
    n.timer = (r.timer == TIMER_MAX) ? r.timer : r.timer + 1'b1;
    case (r.an_st)
      pcs_link_pkg::AN_OFF: begin
        n.an_st = pcs_link_pkg::AN_ABILITY;
        n.timer = '0;
      end
      pcs_link_pkg::AN_ABILITY: begin
        if (code_error) begin // R09
          n.timer = '0;
        end else if (partner_ability && r.timer == TIMER_MAX) begin // R10
          n.an_st = pcs_link_pkg::AN_ACK;
          n.timer = '0;
        end
      end
      pcs_link_pkg::AN_ACK: begin
        if (code_error) begin // R09
          n.an_st = pcs_link_pkg::AN_ABILITY;
          n.timer = '0;
        end else if (partner_ack && r.timer == TIMER_MAX) begin // R10
          n.an_st = pcs_link_pkg::AN_DONE;
        end
      end
      pcs_link_pkg::AN_DONE: n.an_st = pcs_link_pkg::AN_DONE;
      default:               n.an_st = pcs_link_pkg::AN_OFF;
    endcase
    if (r.restart || r.sync_st != pcs_link_pkg::SYNC_OK) begin
      n.an_st = pcs_link_pkg::AN_ABILITY;
      n.timer = '0;
    end
    if (!r.an_en) begin
      n.an_st = pcs_link_pkg::AN_OFF;
    end

    // status vector and events
    link_new  = link_of(n.sync_st, n.an_st, n.an_en);
    n.sv      = {link_new, n.sync_st == pcs_link_pkg::SYNC_OK}; // R03
    n.link_prev = link_new;
    ev[pcs_link_pkg::IRQ_AN_DONE] = !an_done && n.an_st == pcs_link_pkg::AN_DONE; // R08
    ev[pcs_link_pkg::IRQ_LINK_UP] = link_new && !r.link_prev;
    ev[pcs_link_pkg::IRQ_LINK_DN] = !link_new && r.link_prev;
    // a new event beats a clear in the same cycle
    n.irq_stat = (r.irq_stat & ~w1c) | ev;
    n.irq      = |(n.irq_stat & n.irq_mask); // R08

    // client datapath; the override skips only the link check
    if (!r.isolate && (link_now || r.unidir)) begin // R04
      n.txd   = gmii_txd;
      n.tx_en = gmii_tx_en;
      n.tx_er = gmii_tx_er;
    end else begin
      n.txd   = '0;
      n.tx_en = 1'b0;
      n.tx_er = 1'b0;
    end
    if (!r.isolate) begin // R05
      n.rxd   = pcs_rxd;
      n.rx_dv = pcs_rx_dv;
      n.rx_er = pcs_rx_er || (pcs_rx_dv && code_error); // R13
    end else begin
      n.rxd   = '0;
      n.rx_dv = 1'b0;
      n.rx_er = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.an_en   <= 1'b1;
      r.isolate <= 1'b1; // R05
      r.gt_rst  <= 1'b1; // R14
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign irq           = r.irq;
  assign mdio_out      = r.m_out;
  assign mdio_oe       = r.m_oe;
  assign gt_tx_reset   = r.gt_rst;
  assign gt_rx_reset   = r.gt_rst;
  assign pcs_txd       = r.txd;
  assign pcs_tx_en     = r.tx_en;
  assign pcs_tx_er     = r.tx_er;
  assign gmii_rxd      = r.rxd;
  assign gmii_rx_dv    = r.rx_dv;
  assign gmii_rx_er    = r.rx_er;
  assign status_vector = r.sv;

endmodule

// ### verif/link_partner.sv
`timescale 1ns/1ps
// ==========================================================
// far-side link partner: medium, code groups, negotiation
module link_partner (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // scenario controls
  input  wire logic       light,
  input  wire logic       an_on,
  input  wire logic       bad,
  // towards the block
  output logic            signal_detect,
  output logic            code_valid,
  output logic            code_error,
  output logic            partner_ability,
  output logic            partner_ack,
  output logic      [7:0] pcs_rxd,
  output logic            pcs_rx_dv,
  output logic            pcs_rx_er
);
  typedef struct packed {
    logic [7:0] cnt;
  } peer_s;
  peer_s st_reg;
  peer_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // light held at 1 stands for the tied-high case
  assign signal_detect   = light;
  assign code_valid      = light & ~bad;
  assign code_error      = light & bad;
  // negotiation words only when this side has it enabled
  assign partner_ability = light & an_on;
  assign partner_ack     = light & an_on;
  // data keeps changing so a stale byte cannot pass for a fresh one
  assign pcs_rxd         = st_reg.cnt ^ 8'hA5;
  assign pcs_rx_dv       = light & st_reg.cnt[3];
  assign pcs_rx_er       = pcs_rx_dv & (st_reg.cnt[2:0] == 3'h7);
endmodule

// ### verif/pcs_link_status_properties.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checker
module pcs_link_checker #(
  parameter int LINK_TIMER_CYC = 16
) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        irq,
  // medium and transceiver
  input wire logic        signal_detect,
  input wire logic        pll_locked,
  input wire logic        gt_tx_reset,
  input wire logic        gt_rx_reset,
  input wire logic        code_error,
  // datapath
  input wire logic        pcs_tx_en,
  input wire logic        pcs_rx_dv,
  input wire logic        pcs_rx_er,
  input wire logic        gmii_rx_dv,
  input wire logic        gmii_rx_er,
  input wire logic [7:0]  gmii_rxd,
  input wire logic [7:0]  pcs_rxd,
  input wire logic [1:0]  status_vector
);
  typedef struct packed {
    logic iso;
    logic uni;
  } shadow_s;
  shadow_s sh_reg;
  shadow_s sh_next;
  logic    ctrl_wr;
  // shadow of the control bits, updated at the edge the write lands
  assign ctrl_wr = psel & penable & pready & pwrite & (paddr == pcs_link_pkg::CTRL_OFF);
  always_comb begin
    sh_next = sh_reg;
    if (ctrl_wr) begin
      sh_next.iso = pwdata[pcs_link_pkg::CTRL_ISOLATE];
      sh_next.uni = pwdata[pcs_link_pkg::CTRL_UNIDIR];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= 2'h2;
    end else begin
      sh_reg <= sh_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_err;
    code_error;
  endsequence
  sequence s_down;
    (!status_vector[1])[*2];
  endsequence
  // ==========================================================
  // properties
  property p_tx_gate;
    pcs_tx_en |-> !$past(sh_reg.iso) &&
      ($past(sh_reg.uni) || status_vector[1] || $past(status_vector[1]));
  endproperty
  property p_rx_iso;
    gmii_rx_dv |-> !$past(sh_reg.iso);
  endproperty
  property p_rx_err;
    gmii_rx_dv |-> gmii_rx_er == $past(pcs_rx_er || (pcs_rx_dv && code_error));
  endproperty
  property p_link_sync;
    status_vector[1] |-> status_vector[0];
  endproperty
  property p_no_medium;
    (!signal_detect)[*5] |-> !status_vector[0];
  endproperty
  property p_err_restart;
    s_err |-> ##2 s_down;
  endproperty
  property p_gt_reset;
    (!pll_locked)[*4] |-> gt_tx_reset && gt_rx_reset;
  endproperty
  property p_stat_link;
    pready && !pwrite && paddr == pcs_link_pkg::STAT_OFF |-> prdata[2] == prdata[17];
  endproperty
  property p_irq_off;
    pready && pwrite && paddr == pcs_link_pkg::IRQ_MASK_OFF && pwdata[2:0] == 3'h0
      |-> ##2 !irq;
  endproperty
  property p_rx_pass;
    !$past(sh_reg.iso) |-> gmii_rxd == $past(pcs_rxd) && gmii_rx_dv == $past(pcs_rx_dv);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit passed while gated");
  a_rx_iso: assert property (p_rx_iso) else $error("receive passed while isolated");
  a_rx_err: assert property (p_rx_err) else $error("receive error not passed on");
  a_link_sync: assert property (p_link_sync) else $error("link without sync");
  a_no_medium: assert property (p_no_medium) else $error("sync without medium");
  a_err_restart: assert property (p_err_restart) else $error("link kept after error");
  a_gt_reset: assert property (p_gt_reset) else $error("gt reset released unlocked");
  a_stat_link: assert property (p_stat_link) else $error("status link bits differ");
  a_irq_off: assert property (p_irq_off) else $error("irq high while all masked");
  a_rx_pass: assert property (p_rx_pass) else $error("receive data not passed on");
endmodule
bind pcs_link_status pcs_link_checker #(.LINK_TIMER_CYC(LINK_TIMER_CYC)) u_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .irq,
  .signal_detect, .pll_locked, .gt_tx_reset, .gt_rx_reset, .code_error, .pcs_tx_en,
  .pcs_rx_dv, .pcs_rx_er, .gmii_rx_dv, .gmii_rx_er, .gmii_rxd, .pcs_rxd, .status_vector);

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int LT = 16;
  localparam int LIMIT = 20000;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, rd, md;
  logic        pll_locked, gt_tx_reset, gt_rx_reset, light, an_on, bad;
  logic        mdc, mdi, mdio_out, mdio_oe;
  logic [4:0]  phy_addr;
  logic        signal_detect, code_valid, code_error, partner_ability, partner_ack;
  logic [7:0]  gmii_txd, pcs_txd, pcs_rxd;
  logic        gmii_tx_en, gmii_tx_er, pcs_tx_en, pcs_tx_er, pcs_rx_dv, pcs_rx_er;
  logic        gmii_rx_dv, gmii_rx_er, care, exp_pass;
  logic [1:0]  status_vector;
  logic [10:0] note_q[$];
  logic [10:0] note;
  int          err_count, samples_checked, cyc_n, n;
  pcs_link_status #(.LINK_TIMER_CYC(LT)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .mdc, .mdio_in(mdi), .mdio_out, .mdio_oe,
    .phy_addr, .signal_detect, .pll_locked, .gt_tx_reset, .gt_rx_reset,
    .code_valid, .code_error, .partner_ability, .partner_ack, .gmii_txd, .gmii_tx_en,
    .gmii_tx_er, .pcs_txd, .pcs_tx_en, .pcs_tx_er, .pcs_rxd, .pcs_rx_dv, .pcs_rx_er,
    .gmii_rxd(), .gmii_rx_dv, .gmii_rx_er, .status_vector);
  link_partner PEER (
    .pclk, .presetn, .light, .an_on, .bad, .signal_detect, .code_valid, .code_error,
    .partner_ability, .partner_ack, .pcs_rxd, .pcs_rx_dv, .pcs_rx_er);
  always #25 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // management station; a bit spans eight cycles, so 2.5 MHz at most
  task automatic mrd(input logic [4:0] a, output logic [31:0] d);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 4'h6, a, pcs_link_pkg::MREG_STAT, 18'h3FFFF};
    for (int i = 63; i >= 0; i--) begin
      mdi <= f[i];
      repeat (4) @(posedge pclk);
      d = {d[30:0], mdio_oe & mdio_out};
      mdc <= 1'h1;
      repeat (4) @(posedge pclk);
      mdc <= 1'h0;
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic wait_link(input logic v);
    n = 0;
    while (status_vector[1] !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // expectations resume only once the gate has settled
  task automatic settle(input logic p);
    repeat (3) @(posedge pclk);
    exp_pass <= p;
    care <= 1'h1;
  endtask
  // ==========================================================
  // transmit stream and scoreboard
  always @(posedge pclk) begin
    if (presetn) begin
      rnd = xs(rnd);
      gmii_txd <= rnd[7:0];
      gmii_tx_en <= rnd[8];
      gmii_tx_er <= rnd[9];
      note_q.push_back({care, exp_pass ? rnd[9:0] : 10'h000});
    end
  end
  always @(negedge pclk) begin
    if (note_q.size() > 1) begin
      note = note_q.pop_front();
      if (note[10]) chk({pcs_tx_er, pcs_tx_en, pcs_txd}, note[9:0]);
    end
  end
  always @(posedge pclk) begin
    cyc_n++;
    if (cyc_n == LIMIT) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    {psel, penable, pwrite, pll_locked, light, bad, presetn} = 7'h00;
    {gmii_txd, gmii_tx_en, gmii_tx_er} = 10'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    {an_on, care, exp_pass} = 3'h6;
    rnd = 32'h0000003D;
    phy_addr = rnd[4:0];
    {mdc, mdi} = 2'h1;
    {err_count, samples_checked, cyc_n} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    chk({gt_tx_reset, gt_rx_reset}, 32'h3);
    pll_locked <= 1'h1;
    repeat (4) @(posedge pclk);
    chk({gt_tx_reset, gt_rx_reset}, 32'h0);
    rchk(pcs_link_pkg::CTRL_OFF, 32'hF, 32'h3);
    rchk(12'h010, 32'hFFFFFFFF, 32'h0);
    chk(er, 32'h1);
    // link comes up while still isolated
    light <= 1'h1;
    wait_link(1'h1);
    rchk(pcs_link_pkg::STAT_OFF, 32'h0003002C, 32'h0003002C);
    mrd(phy_addr, md);
    chk(md, 32'h0000002C);
    mrd(phy_addr ^ 5'h01, md);
    chk(md, 32'h0);
    chk(irq, 32'h0);
    apb(1'h1, pcs_link_pkg::IRQ_MASK_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1'h1, pcs_link_pkg::IRQ_STAT_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    rchk(pcs_link_pkg::IRQ_STAT_OFF, 32'h7, 32'h2);
    care <= 1'h0;
    apb(1'h1, pcs_link_pkg::CTRL_OFF, 32'h1);
    settle(1'h1);
    repeat (20) @(posedge pclk);
    // errors: one on a live link, one inside the handshake
    care <= 1'h0;
    bad <= 1'h1;
    @(posedge pclk);
    bad <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(status_vector[1], 32'h0);
    repeat (12) @(posedge pclk);
    bad <= 1'h1;
    @(posedge pclk);
    bad <= 1'h0;
    wait_link(1'h1);
    chk(n >= 2 * LT && n < 400, 32'h1);
    settle(1'h1);
    repeat (10) @(posedge pclk);
    // partner will not negotiate
    care <= 1'h0;
    an_on <= 1'h0;
    apb(1'h1, pcs_link_pkg::CTRL_OFF, 32'h9);
    settle(1'h0);
    repeat (4 * LT) @(posedge pclk);
    rchk(pcs_link_pkg::STAT_OFF, 32'h00020024, 32'h0);
    care <= 1'h0;
    apb(1'h1, pcs_link_pkg::CTRL_OFF, 32'h0);
    wait_link(1'h1);
    chk(n < 400, 32'h1);
    settle(1'h1);
    repeat (10) @(posedge pclk);
    // medium lost
    care <= 1'h0;
    light <= 1'h0;
    repeat (6) @(posedge pclk);
    rchk(pcs_link_pkg::STAT_OFF, 32'h00030004, 32'h0);
    settle(1'h0);
    repeat (10) @(posedge pclk);
    care <= 1'h0;
    apb(1'h1, pcs_link_pkg::CTRL_OFF, 32'h4);
    settle(1'h1);
    repeat (20) @(posedge pclk);
    apb(1'h1, pcs_link_pkg::IRQ_MASK_OFF, 32'h0);
    repeat (4) @(posedge pclk);
    test_done;
  end
endmodule
